// ### design/sfn_datapath.v
/*
  Special-value stage of a 128-bit vector floating-point unit: NaN
  selection and quieting, flush-to-zero with its exception flags,
  element broadcast, offset scaling and widening operand layout.
  Assumes the arithmetic unit supplies raw results, pre-rounding
  tiny flags and invalid flags per lane; all inputs share clk.
*/
`timescale 1ns/100ps
`include "sfn_defines.vh"
module sfn_datapath (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // request
  input  wire         op_valid,
  input  wire [1:0]   element_format_select,
  input  wire [1:0]   src_format_select,
  input  wire         convert_en,
  input  wire [1:0]   op_kind,
  input  wire [1:0]   operand_count,
  input  wire         flush_subnormal_enable,
  input  wire         no_subnormal_support,
  input  wire [127:0] opnd_a,
  input  wire [127:0] opnd_b,
  input  wire [127:0] opnd_c,
  // element select, offset and widening sign
  input  wire         element_select_en,
  input  wire [3:0]   element_index,
  input  wire [9:0]   scaled_signed_offset,
  input  wire         widen_signed,
  // arithmetic unit side
  input  wire [127:0] raw_result,
  input  wire [7:0]   tiny_before_round,
  input  wire [7:0]   arith_invalid,
  // answer
  output reg          res_valid,
  output reg  [127:0] result,
  output reg          exc_invalid,
  output reg          exc_underflow,
  output reg          exc_inexact,
  output reg          exc_unimplemented,
  output reg          index_invalid,
  output reg  [12:0]  byte_offset,
  output reg  [127:0] widen_even,
  output reg  [127:0] widen_odd
);

  // field summary {sign, exp all ones, exp zero, mantissa nonzero, mantissa msb}
  function [4:0] f_cls;
    input [63:0] x;
    input [1:0]  f;
    begin
      case (f)
        `SFN_FMT_H: f_cls = {x[15], &x[14:10], ~|x[14:10], |x[9:0], x[9]};
        `SFN_FMT_W: f_cls = {x[31], &x[30:23], ~|x[30:23], |x[22:0], x[22]};
        default:    f_cls = {x[63], &x[62:52], ~|x[62:52], |x[51:0], x[51]};
      endcase
    end
  endfunction

  // signed zero in format f, sign taken from x
  function [63:0] f_zero;
    input [63:0] x;
    input [1:0]  f;
    begin
      case (f)
        `SFN_FMT_H: f_zero = {48'h0, x[15], 15'h0};
        `SFN_FMT_W: f_zero = {32'h0, x[31], 31'h0};
        default:    f_zero = {x[63], 63'h0};
      endcase
    end
  endfunction

  // quiet a NaN from format sf into format df
  function [63:0] f_quiet;
    input [63:0] x;
    input [1:0]  sf, df;
    reg   [51:0] m;
    reg   [4:0]  cl;
    begin
      case (sf)
        `SFN_FMT_H: m = {x[9:0], 42'h0};
        `SFN_FMT_W: m = {x[22:0], 29'h0};
        default:    m = x[51:0];
      endcase
      cl = f_cls(x, sf);
      // sign and upper mantissa; low bits zeroed or dropped
      case (df)
        `SFN_FMT_H: f_quiet = {48'h0, cl[4], 5'h1F, 1'b1, m[50:42]};
        `SFN_FMT_W: f_quiet = {32'h0, cl[4], 8'hFF, 1'b1, m[50:29]};
        default:    f_quiet = {cl[4], 11'h7FF, 1'b1, m[50:0]};
      endcase
    end
  endfunction

  // element i of vec in format f, low aligned
  function [63:0] f_elem;
    input [127:0] vec;
    input [1:0]   f;
    input integer i;
    begin
      case (f)
        `SFN_FMT_H: f_elem = {48'h0, vec[i*16 +: 16]};
        `SFN_FMT_W: f_elem = i[2] ? 64'h0 : {32'h0, vec[i[1:0]*32 +: 32]};
        default:    f_elem = (i[2:1] != 2'h0) ? 64'h0 : vec[i[0]*64 +: 64];
      endcase
    end
  endfunction

  // one lane: returns {invalid, underflow, inexact, unimplemented, value}
  function [67:0] f_lane;
    input [63:0] a, b, c, r;
    input [1:0]  sf, df, nops, kind;
    input        fz, tiny, ainv, nosub;
    reg   [4:0]  ca, cb, cc;
    reg   [2:0]  vld, nan, snan, sub;
    reg          flush_on, has_sub, inv, unf, inx, uni;
    reg   [63:0] val;
    begin
      ca = f_cls(a, sf);
      cb = f_cls(b, df);
      cc = f_cls(c, df);
      vld = {nops == 2'h3, nops >= 2'h2, 1'b1};
      nan = {cc[3] & cc[1], cb[3] & cb[1], ca[3] & ca[1]} & vld;
      snan = nan & ~{cc[0], cb[0], ca[0]};
      sub = {cc[2] & cc[1] & (df != `SFN_FMT_H),
             cb[2] & cb[1] & (df != `SFN_FMT_H),
             ca[2] & ca[1] & (sf != `SFN_FMT_H)} & vld;
      has_sub = |sub;
      flush_on = fz & (kind != `SFN_KIND_NONAR);
      inv = |snan;
      unf = 1'b0;
      inx = flush_on & has_sub & (kind != `SFN_KIND_CMP);
      uni = ~fz & nosub & (kind != `SFN_KIND_NONAR) & (has_sub | tiny);
      // signaling first, left to right, single NaN
      if (snan[0])
        val = f_quiet(a, sf, df);
      else if (snan[1])
        val = f_quiet(b, df, df);
      else if (snan[2])
        val = f_quiet(c, df, df);
      else if (nan[0])
        val = f_quiet(a, sf, df);
      else if (nan[1])
        val = f_quiet(b, df, df);
      else if (nan[2])
        val = f_quiet(c, df, df);
      else if (ainv) begin
        case (df)
          `SFN_FMT_H: val = `SFN_QNAN_H;
          `SFN_FMT_W: val = `SFN_QNAN_W;
          default:    val = `SFN_QNAN_D;
        endcase
      end else if (flush_on & (df != `SFN_FMT_H) & tiny) begin
        // tiny before rounding flushed to signed zero
        val = f_zero(r, df);
        unf = (kind != `SFN_KIND_RECIP);
        inx = inx | (kind != `SFN_KIND_RECIP);
      end else
        val = r;
      f_lane = {inv, unf, inx, uni, val};
    end
  endfunction

  reg  [127:0] b_eff;
  reg          idx_bad;
  always @* begin
    case (element_format_select)
      `SFN_FMT_B: idx_bad = 1'b0;
      `SFN_FMT_H: idx_bad = element_index[3];
      `SFN_FMT_W: idx_bad = |element_index[3:2];
      default:    idx_bad = |element_index[3:1];
    endcase
    case (element_format_select)
      `SFN_FMT_B: b_eff = {16{opnd_b[element_index*8 +: 8]}};
      `SFN_FMT_H: b_eff = {8{opnd_b[element_index[2:0]*16 +: 16]}};
      `SFN_FMT_W: b_eff = {4{opnd_b[element_index[1:0]*32 +: 32]}};
      default:    b_eff = {2{opnd_b[element_index[0]*64 +: 64]}};
    endcase
    if (!element_select_en)
      b_eff = opnd_b;
  end

  wire [1:0]   sfmt = convert_en ? src_format_select : element_format_select;
  wire [1:0]   nops = convert_en ? 2'h1 : operand_count;
  wire [127:0] h_val, w_val, d_val;
  wire [31:0]  h_flg;
  wire [15:0]  w_flg;
  wire [7:0]   d_flg;
  wire [127:0] we_h, wo_h, we_w, wo_w, we_d, wo_d;

  // per lane special-value handling and widening layout
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_lane
      wire [67:0] lh;
      assign lh = f_lane(convert_en ? f_elem(opnd_a, sfmt, i) : {48'h0, opnd_a[i*16 +: 16]},
                         {48'h0, b_eff[i*16 +: 16]}, {48'h0, opnd_c[i*16 +: 16]},
                         {48'h0, raw_result[i*16 +: 16]}, convert_en ? sfmt : `SFN_FMT_H,
                         `SFN_FMT_H, nops, op_kind, flush_subnormal_enable,
                         tiny_before_round[i], arith_invalid[i], no_subnormal_support);
      assign h_val[i*16 +: 16] = lh[15:0];
      assign h_flg[i*4 +: 4]   = lh[67:64];
      // even and odd bytes into halfwords
      assign we_h[i*16 +: 16] = {{8{widen_signed & opnd_a[i*16+7]}}, opnd_a[i*16 +: 8]};
      assign wo_h[i*16 +: 16] = {{8{widen_signed & opnd_a[i*16+15]}}, opnd_a[i*16+8 +: 8]};
      if (i < 4) begin : g_word
        wire [67:0] lw;
        assign lw = f_lane(convert_en ? f_elem(opnd_a, sfmt, i) : {32'h0, opnd_a[i*32 +: 32]},
                           {32'h0, b_eff[i*32 +: 32]}, {32'h0, opnd_c[i*32 +: 32]},
                           {32'h0, raw_result[i*32 +: 32]}, convert_en ? sfmt : `SFN_FMT_W,
                           `SFN_FMT_W, nops, op_kind, flush_subnormal_enable,
                           tiny_before_round[i], arith_invalid[i], no_subnormal_support);
        assign w_val[i*32 +: 32] = lw[31:0];
        assign w_flg[i*4 +: 4]   = lw[67:64];
        assign we_w[i*32 +: 32] = {{16{widen_signed & opnd_a[i*32+15]}}, opnd_a[i*32 +: 16]};
        assign wo_w[i*32 +: 32] = {{16{widen_signed & opnd_a[i*32+31]}}, opnd_a[i*32+16 +: 16]};
      end
      if (i < 2) begin : g_dbl
        wire [67:0] ld;
        assign ld = f_lane(convert_en ? f_elem(opnd_a, sfmt, i) : opnd_a[i*64 +: 64],
                           b_eff[i*64 +: 64], opnd_c[i*64 +: 64], raw_result[i*64 +: 64],
                           convert_en ? sfmt : `SFN_FMT_D, `SFN_FMT_D, nops, op_kind,
                           flush_subnormal_enable, tiny_before_round[i], arith_invalid[i],
                           no_subnormal_support);
        assign d_val[i*64 +: 64] = ld[63:0];
        assign d_flg[i*4 +: 4]   = ld[67:64];
        assign we_d[i*64 +: 64] = {{32{widen_signed & opnd_a[i*64+31]}}, opnd_a[i*64 +: 32]};
        assign wo_d[i*64 +: 64] = {{32{widen_signed & opnd_a[i*64+63]}}, opnd_a[i*64+32 +: 32]};
      end
    end
  endgenerate

  // select lanes of the active format and merge lane flags
  reg [127:0] val_next, we_next, wo_next;
  reg [3:0]   flg_next;
  integer k;
  always @* begin
    flg_next = 4'h0;
    case (element_format_select)
      `SFN_FMT_H: begin
        val_next = h_val;
        we_next  = we_h;
        wo_next  = wo_h;
        for (k = 0; k < 8; k = k + 1)
          flg_next = flg_next | h_flg[k*4 +: 4];
      end
      `SFN_FMT_W: begin
        val_next = w_val;
        we_next  = we_w;
        wo_next  = wo_w;
        for (k = 0; k < 4; k = k + 1)
          flg_next = flg_next | w_flg[k*4 +: 4];
      end
      `SFN_FMT_D: begin
        val_next = d_val;
        we_next  = we_d;
        wo_next  = wo_d;
        for (k = 0; k < 2; k = k + 1)
          flg_next = flg_next | d_flg[k*4 +: 4];
      end
      default: begin
        val_next = raw_result;  // no byte floating point
        we_next  = 128'h0;
        wo_next  = 128'h0;
      end
    endcase
  end

  wire [12:0] ofs_next = {{3{scaled_signed_offset[9]}}, scaled_signed_offset}
                         << element_format_select;
  // output registers, loaded on each accepted request
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_valid         <= 1'b0;
      result            <= 128'h0;
      exc_invalid       <= 1'b0;
      exc_underflow     <= 1'b0;
      exc_inexact       <= 1'b0;
      exc_unimplemented <= 1'b0;
      index_invalid     <= 1'b0;
      byte_offset       <= 13'h0;
      widen_even        <= 128'h0;
      widen_odd         <= 128'h0;
    end else begin
      res_valid <= op_valid;
      if (op_valid) begin
        result            <= val_next;
        exc_invalid       <= flg_next[3];
        exc_underflow     <= flg_next[2];
        exc_inexact       <= flg_next[1];
        exc_unimplemented <= flg_next[0];
        index_invalid     <= element_select_en & idx_bad;
        byte_offset       <= ofs_next;
        widen_even        <= we_next;
        widen_odd         <= wo_next;
      end
    end
  end
endmodule

// ### include/sfn_defines.vh
/*
  Constants for the vector floating-point special-value datapath:
  element format codes, operation kinds, element widths and the
  default quiet NaN encodings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SFN_DEFINES_VH
`define SFN_DEFINES_VH

// vector register width
`define SFN_VEC_W      128

// element format codes (element_format_select)
`define SFN_FMT_B      2'h0
`define SFN_FMT_H      2'h1
`define SFN_FMT_W      2'h2
`define SFN_FMT_D      2'h3

// element widths in bits
`define SFN_EW_B       8
`define SFN_EW_H       16
`define SFN_EW_W       32
`define SFN_EW_D       64

// operation kinds
`define SFN_KIND_ARITH 2'h0
`define SFN_KIND_CMP   2'h1
`define SFN_KIND_RECIP 2'h2
`define SFN_KIND_NONAR 2'h3

// default quiet NaN per format
`define SFN_QNAN_H     64'h0000_0000_0000_7E00
`define SFN_QNAN_W     64'h0000_0000_7FC0_0000
`define SFN_QNAN_D     64'h7FF8_0000_0000_0000

// load/store offset widths
`define SFN_OFS_W      10
`define SFN_BOFS_W     13

`endif

// ### bench/sfn_datapath_asserts.sv
/*
  port checker for the special-value datapath
  assumes one clock domain, bound into sfn_datapath
*/
`timescale 1ns/100ps
`include "sfn_defines.vh"

module sfn_datapath_chk (
  // clock and reset
  input wire         clk,
  input wire         nrst,
  // request
  input wire         op_valid,
  input wire [1:0]   element_format_select,
  input wire         convert_en,
  input wire [1:0]   op_kind,
  input wire [1:0]   operand_count,
  input wire         flush_subnormal_enable,
  input wire         no_subnormal_support,
  input wire [127:0] opnd_a,
  input wire         element_select_en,
  input wire [3:0]   element_index,
  input wire [9:0]   scaled_signed_offset,
  input wire [127:0] raw_result,
  input wire [7:0]   tiny_before_round,
  input wire [7:0]   arith_invalid,
  // answer
  input wire [127:0] result,
  input wire         exc_invalid,
  input wire         exc_underflow,
  input wire         exc_inexact,
  input wire         exc_unimplemented,
  input wire         index_invalid,
  input wire [12:0]  byte_offset
);
  // word lane 0 qualifiers
  wire        w_req  = op_valid && element_format_select == `SFN_FMT_W && !convert_en;
  wire        fz     = flush_subnormal_enable;
  wire        a_snan = opnd_a[30:22] == 9'h1FE && opnd_a[21:0] != 22'h0;
  wire        a_sub  = opnd_a[30:23] == 8'h00 && opnd_a[22:0] != 23'h0;
  // single ordinary operand, no default-NaN override on lane 0
  wire        w_plain = operand_count == 2'h1 && opnd_a[30:23] != 8'hFF && !arith_invalid[0];
  wire [12:0] ofs_x  = {{3{scaled_signed_offset[9]}}, scaled_signed_offset};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_single_qnan: assert property (w_req && op_kind == `SFN_KIND_ARITH &&
    operand_count == 2'h1 && opnd_a[30:22] == 9'h1FF
    |=> result[31:0] == $past(opnd_a[31:0])) else $error("quiet nan not passed");
  a_snan_invalid: assert property (w_req && op_kind == `SFN_KIND_ARITH && a_snan
    |=> exc_invalid) else $error("signaling nan without invalid");
  a_quiet_copy: assert property (w_req && op_kind == `SFN_KIND_ARITH && a_snan
    |=> result[31:0] == {$past(opnd_a[31]), 9'h1FF, $past(opnd_a[21:0])})
    else $error("quieted nan malformed");
  a_flush_tiny: assert property (w_req && fz && op_kind != `SFN_KIND_NONAR &&
    tiny_before_round[0] && w_plain
    |=> result[31:0] == {$past(raw_result[31]), 31'h0}) else $error("tiny not flushed");
  a_tiny_flags: assert property (w_req && fz && op_kind == `SFN_KIND_ARITH &&
    tiny_before_round[0] && w_plain |=> exc_underflow && exc_inexact)
    else $error("tiny flags missing");
  a_recip_quiet: assert property (op_valid && fz && op_kind == `SFN_KIND_RECIP
    |=> !exc_underflow) else $error("reciprocal raised underflow");
  a_cmp_exact: assert property (op_valid && fz && op_kind == `SFN_KIND_CMP &&
    tiny_before_round == 8'h0 |=> !exc_inexact) else $error("compare raised inexact");
  a_unimp_raise: assert property (w_req && !fz && no_subnormal_support && a_sub &&
    op_kind == `SFN_KIND_ARITH && operand_count == 2'h1
    |=> exc_unimplemented) else $error("unimplemented not raised");
  a_index_range: assert property (op_valid && element_select_en
    |=> index_invalid == ($past(element_index) > (4'hF >> $past(element_format_select))))
    else $error("index range wrong");
  a_offset_scale: assert property (op_valid
    |=> byte_offset == ($past(ofs_x) << $past(element_format_select)))
    else $error("offset scaling wrong");

  // main scenarios reached
  c_flush: cover property (w_req && fz && tiny_before_round[0]);
  c_index: cover property (op_valid && element_select_en);
  c_snan: cover property (w_req && a_snan);
endmodule

bind sfn_datapath sfn_datapath_chk u_chk (
  .clk(clk), .nrst(nrst), .op_valid(op_valid), .element_format_select(element_format_select),
  .convert_en(convert_en), .op_kind(op_kind), .operand_count(operand_count),
  .flush_subnormal_enable(flush_subnormal_enable), .no_subnormal_support(no_subnormal_support),
  .opnd_a(opnd_a), .element_select_en(element_select_en), .element_index(element_index),
  .scaled_signed_offset(scaled_signed_offset), .raw_result(raw_result),
  .tiny_before_round(tiny_before_round), .arith_invalid(arith_invalid), .result(result),
  .exc_invalid(exc_invalid),
  .exc_underflow(exc_underflow), .exc_inexact(exc_inexact),
  .exc_unimplemented(exc_unimplemented), .index_invalid(index_invalid),
  .byte_offset(byte_offset));

// ### bench/sfn_pipe_model.sv
/*
  pipeline-side model: raises the request strobe
  assumes the request fields were set one edge earlier
*/
`timescale 1ns/100ps

module sfn_pipe_model (
  // clock
  input  wire  clk,
  // answer
  input  wire  res_valid,
  // request strobe
  output logic op_valid
);
  // strobe idle from time zero
  initial op_valid = 1'b0;

  // one-cycle strobe, answer taken at the edge where it stands
  task automatic issue(output logic seen);
    @(posedge clk);
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    seen = res_valid;
  endtask
endmodule

// ### bench/sfn_datapath_test.sv
/*
  self-checking bench for the special-value datapath
  assumes the pipeline model strobes, fields come from drv
*/
`timescale 1ns/100ps
`include "sfn_defines.vh"

module sfn_datapath_test;
  typedef struct packed {
    logic [1:0]   fmt, sfmt, kind, cnt;
    logic         cv, fz, nosub, es, ws;
    logic [3:0]   idx;
    logic [9:0]   ofs;
    logic [127:0] a, b, c, raw;
    logic [7:0]   tiny, ainv;
  } sfn_req_t;

  logic         clk;
  logic         nrst;
  logic         seen;
  wire          op_valid;
  wire          res_valid;
  sfn_req_t     rq;
  sfn_req_t     drv;
  wire [127:0]  result, widen_even, widen_odd;
  wire          exc_invalid, exc_underflow, exc_inexact, exc_unimplemented, index_invalid;
  wire [12:0]   byte_offset;
  int           errors;
  int           checks;

  // device and pipeline model
  sfn_datapath DUT (.clk(clk), .nrst(nrst), .op_valid(op_valid),
    .element_format_select(drv.fmt), .src_format_select(drv.sfmt), .convert_en(drv.cv),
    .op_kind(drv.kind), .operand_count(drv.cnt), .flush_subnormal_enable(drv.fz),
    .no_subnormal_support(drv.nosub), .opnd_a(drv.a), .opnd_b(drv.b), .opnd_c(drv.c),
    .element_select_en(drv.es), .element_index(drv.idx), .scaled_signed_offset(drv.ofs),
    .widen_signed(drv.ws), .raw_result(drv.raw), .tiny_before_round(drv.tiny),
    .arith_invalid(drv.ainv), .res_valid(res_valid), .result(result),
    .exc_invalid(exc_invalid), .exc_underflow(exc_underflow), .exc_inexact(exc_inexact),
    .exc_unimplemented(exc_unimplemented), .index_invalid(index_invalid),
    .byte_offset(byte_offset), .widen_even(widen_even), .widen_odd(widen_odd));
  sfn_pipe_model pm (.clk(clk), .res_valid(res_valid), .op_valid(op_valid));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [63:0] ext(input logic [31:0] v, input logic s);
    return {{32{s & v[31]}}, v};
  endfunction

  // fields on one edge, strobe on the next
  task automatic go;
    @(posedge clk);
    drv <= rq;
    pm.issue(seen);
    chk("res_valid", seen, 1'b1);
  endtask

  task automatic t_nan;
    logic [31:0] av[5] = '{32'h3F800000, 32'h7FC00011, 32'hFF800007, 32'h7FC00011, 32'h3F800000};
    logic [31:0] bv[5] = '{32'h7FC00022, 32'h7F800005, 32'h0, 32'h0, 32'h0};
    logic [31:0] cw[5] = '{32'h7FC00033, 32'h7F800006, 32'h0, 32'h0, 32'h0};
    logic [31:0] ev[5] = '{32'h7FC00022, 32'h7FC00005, 32'hFFC00007, 32'h7FC00011, 32'h7FC00000};
    logic [3:0]  ct[5] = '{4'h3, 4'h7, 4'h5, 4'h1, 4'h9};
    for (int i = 0; i < 5; i++) begin
      rq = '0;
      rq.fmt = `SFN_FMT_W;
      rq.cnt = ct[i][1:0];
      rq.a = {4{av[i]}};
      rq.b = {4{bv[i]}};
      rq.c = {4{cw[i]}};
      rq.raw = {4{32'h3F800000}};
      rq.ainv = {8{ct[i][3]}};
      go();
      chk("nan result", result, {4{ev[i]}});
      chk("invalid", exc_invalid, ct[i][2]);
    end
  endtask

  task automatic t_conv;
    rq = '0;
    rq.fmt = `SFN_FMT_W;
    rq.sfmt = `SFN_FMT_D;
    rq.cv = 1'b1;
    rq.cnt = 2'h1;
    rq.a = {2{64'hFFF4_0000_0000_0001}};
    go();
    chk("narrow nan", result[63:0], {2{32'hFFE00000}});
    rq.fmt = `SFN_FMT_D;
    rq.sfmt = `SFN_FMT_W;
    rq.a = {4{32'h7F800005}};
    go();
    chk("wide nan", result, {2{64'h7FF8_0000_A000_0000}});
  endtask

  task automatic t_flush;
    logic [7:0] tb[6] = '{8'h2E, 8'hA8, 8'h34, 8'h70, 8'hF0, 8'h11};
    for (int i = 0; i < 6; i++) begin
      rq = '0;
      rq.fmt = `SFN_FMT_W;
      rq.kind = tb[i][7:6];
      rq.fz = tb[i][5];
      rq.nosub = 1'b1;
      rq.cnt = 2'h1;
      rq.a = tb[i][4] ? {4{32'h80000001}} : {4{32'h3F800000}};
      rq.tiny = {4'h0, {4{tb[i][3]}}};
      rq.raw = {4{32'h80000003}};
      go();
      chk("flushed", result, tb[i][3] ? {4{32'h80000000}} : rq.raw);
      chk("flags", {exc_inexact, exc_underflow, exc_unimplemented}, tb[i][2:0]);
    end
    rq.fmt = `SFN_FMT_H;
    rq.fz = 1'b1;
    rq.a = {8{16'h0001}};
    rq.tiny = 8'hFF;
    rq.raw = {8{16'h8003}};
    go();
    chk("half kept", result, rq.raw);
    chk("half flags", {exc_inexact, exc_underflow}, 2'h0);
  endtask

  task automatic t_sel;
    rq = '0;
    rq.fmt = `SFN_FMT_W;
    rq.cnt = 2'h2;
    rq.es = 1'b1;
    rq.idx = 4'h2;
    rq.a = {4{32'h3F800000}};
    rq.b = {32'h3F800000, 32'h7FC00077, 32'h3F800000, 32'h3F800000};
    go();
    chk("broadcast", result, {4{32'h7FC00077}});
    for (int f = 0; f < 4; f++) begin
      rq.fmt = f[1:0];
      rq.idx = 4'hF >> f;
      go();
      chk("index ok", index_invalid, 1'b0);
      rq.idx = rq.idx + 4'h1; // byte index wraps to 0
      go();
      chk("index bad", index_invalid, f != 0);
    end
  endtask

  task automatic t_ofs;
    logic [12:0] e;
    rq = '0;
    for (int f = 0; f < 4; f++) begin
      rq.fmt = f[1:0];
      rq.ofs = f[0] ? 10'h1FF : 10'h200;
      e = (f[0] ? 13'h01FF : 13'h1E00) << f;
      go();
      chk("byte offset", byte_offset, e);
    end
  endtask

  task automatic t_wide;
    logic [31:0] w[4] = '{32'h80000001, 32'h00000002, 32'hFFFFFFFF, 32'h7FFFFFFF};
    rq = '0;
    rq.fmt = `SFN_FMT_D;
    rq.a = {w[3], w[2], w[1], w[0]};
    for (int s = 0; s < 2; s++) begin
      rq.ws = s[0];
      go();
      chk("widen even", widen_even, {ext(w[2], s[0]), ext(w[0], s[0])});
      chk("widen odd", widen_odd, {ext(w[3], s[0]), ext(w[1], s[0])});
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard far past the expected run
  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    drv = '0;
    errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_nan();
    t_conv();
    t_flush();
    t_sel();
    t_ofs();
    t_wide();
    end_of_test();
  end
endmodule
